// ===== pfbs_defs.svh
// Functional notes
// R1 - Primary block holds 128 or 256 sectors of 128 bytes, by size variant.
// R2 - Secondary 8 KByte block holds 64 sectors of 128 bytes.
// R3 - Low seven address bits pick the byte, higher bits pick the sector.
// R4 - Field 10 or 11 hides secondary from fetch; programming reaches it at E000H-FFFFH.
// R5 - Field 01 maps primary at 0000H-7FFFH and secondary at E000H-FFFFH for fetch.
// R6 - Field 00 fetches 0000H-1FFFH from the secondary block.
// R7 - Field 00 fetches primary elsewhere; programming still reaches low primary.
// R8 - Every reset loads the field from the two start-up bits by reset type.
// R9 - Start-up bits change only by host-mode or in-application programming command.
// R10 - Software may rewrite field bit 0 anytime; start-up bit 0 stays unchanged. Writes in INIT or with a reset event are dropped.
// R11 - Software must not switch mapping while running from 0000H-1FFFH.
// R12 - Reset table: power-on inverts both; watchdog/brown-out and software per type.
// R13 - Each fetch decodes with the current field; changes apply from next fetch.
`ifndef PFBS_DEFS_SVH
`define PFBS_DEFS_SVH

// Register offsets
`define PFBS_OFS_FIELD   4'h0
`define PFBS_OFS_CFG     4'h1
`define PFBS_OFS_STATUS  4'h2

// Field, start-up bit and read-data reset values
`define PFBS_FIELD_RST   2'h0
`define PFBS_SC_ERASED   2'h3
`define PFBS_RDATA_RST   8'h00

// Address map
`define PFBS_BYTE_BITS   7
`define PFBS_SEC_BASE    16'hE000
`define PFBS_OVL_TOP     16'h1FFF
`define PFBS_KBYTE       1024

// Status register fields
`define PFBS_ST_KIND_LSB 0
`define PFBS_ST_BIG_BIT  2
`define PFBS_ST_RUN_BIT  3

`endif

// ===== pfbs_pkg.sv
`include "pfbs_defs.svh"
package pfbs_pkg;

	// Which memory answers an access
	typedef enum logic [1:0] {
		PFBS_BLK_NONE = 2'h0,
		PFBS_BLK_PRI  = 2'h1,
		PFBS_BLK_SEC  = 2'h2
	} pfbs_blk_t;

	// Kind of reset that reloads the field
	typedef enum logic [1:0] {
		PFBS_RST_POR  = 2'h0,
		PFBS_RST_WDT  = 2'h1,
		PFBS_RST_SOFT = 2'h2
	} pfbs_rst_kind_t;

	// Origin of a start-up bit programming command
	typedef enum logic [1:0] {
		PFBS_SRC_NONE = 2'h0,
		PFBS_SRC_HOST = 2'h1,
		PFBS_SRC_IAP  = 2'h2
	} pfbs_cfg_src_t;

	// Controller states
	typedef enum logic [1:0] {
		PFBS_ST_INIT = 2'b01,
		PFBS_ST_RUN  = 2'b10
	} pfbs_state_t;

	// Decoded access: block, sector and byte within sector
	typedef struct packed {
		pfbs_blk_t  blk;
		logic [7:0] sector;
		logic [6:0] offset;
	} pfbs_map_t;

	// Request carrier for a fetch or programming access
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} pfbs_req_t;

endpackage

// ===== pfbs_decode.sv
`timescale 1ns/1ps
`include "pfbs_defs.svh"
module pfbs_decode #(
	parameter int PRI_KB = 32
) (
	input  wire logic             prog_i,
	input  wire logic [1:0]       field_i,
	input  wire logic [15:0]      addr_i,
	output pfbs_pkg::pfbs_map_t   map_o
);
	import pfbs_pkg::*;

	localparam logic [16:0] PRI_END = 17'(PRI_KB * `PFBS_KBYTE);

	logic in_pri;
	logic in_sec_hi;
	logic in_low;

	// Address windows
	assign in_pri    = {1'b0, addr_i} < PRI_END;
	assign in_sec_hi = addr_i >= `PFBS_SEC_BASE;
	assign in_low    = addr_i <= `PFBS_OVL_TOP;

	// Block selection, then sector and byte split
	always_comb begin
		map_o.blk = PFBS_BLK_NONE;
		if (prog_i) begin
			if (in_sec_hi) begin
				map_o.blk = PFBS_BLK_SEC; // R4
			end else if (in_pri) begin
				map_o.blk = PFBS_BLK_PRI; // R7
			end
		end else begin
			case (field_i)
				2'b00: begin
					if (in_low) begin
						map_o.blk = PFBS_BLK_SEC; // R6
					end else if (in_pri) begin
						map_o.blk = PFBS_BLK_PRI; // R7
					end
				end
				2'b01: begin
					if (in_pri) begin
						map_o.blk = PFBS_BLK_PRI; // R5
					end else if (in_sec_hi) begin
						map_o.blk = PFBS_BLK_SEC; // R5
					end
				end
				default: begin
					if (in_pri) begin
						map_o.blk = PFBS_BLK_PRI; // R4
					end
				end
			endcase
		end
		map_o.offset = addr_i[`PFBS_BYTE_BITS-1:0]; // R3
		if (map_o.blk == PFBS_BLK_SEC) begin
			map_o.sector = {2'h0, addr_i[12:`PFBS_BYTE_BITS]}; // R2 R3
		end else if (map_o.blk == PFBS_BLK_PRI) begin
			map_o.sector = addr_i[14:`PFBS_BYTE_BITS]; // R1 R3
		end else begin
			map_o.sector = 8'h00;
		end
	end

endmodule // pfbs_decode

// ===== pfbs_top.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pfbs_defs.svh"
module pfbs_top #(
	parameter int PRI_KB = 32
) (
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	// Register port
	input  wire logic [3:0]              reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [7:0]                   reg_rdata_o,
	// Reset events from the reset controller
	input  wire logic                    sys_rst_req_i,
	input  pfbs_pkg::pfbs_rst_kind_t     sys_rst_kind_i,
	// Start-up bit programming command
	input  wire logic                    cfg_wr_i,
	input  pfbs_pkg::pfbs_cfg_src_t      cfg_src_i,
	input  wire logic [1:0]              cfg_wdata_i,
	// Instruction fetch
	input  pfbs_pkg::pfbs_req_t          fetch_i,
	output logic                         fetch_valid_o,
	output pfbs_pkg::pfbs_map_t          fetch_map_o,
	// In-application programming access
	input  pfbs_pkg::pfbs_req_t          prog_i,
	output logic                         prog_valid_o,
	output pfbs_pkg::pfbs_map_t          prog_map_o,
	// Mapping state
	output logic [1:0]                   block_switch_field_o,
	output logic                         startup_cfg_bit0_o,
	output logic                         startup_cfg_bit1_o,
	output logic                         map_changed_o
);
	import pfbs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////////////////////

	pfbs_state_t    state;
	pfbs_state_t    next_state;
	logic [1:0]     block_switch_field;
	logic [1:0]     next_field;
	logic           startup_cfg_bit0;
	logic           startup_cfg_bit1;
	pfbs_rst_kind_t last_kind;
	pfbs_map_t      fetch_map;
	pfbs_map_t      prog_map;
	logic           field_wr;
	logic           cfg_ok;
	logic           reload;
	pfbs_rst_kind_t reload_kind;
	logic [7:0]     next_rdata;
	logic [7:0]     status_word;
	logic [1:0]     field_d;

	localparam logic BIG_VARIANT = (PRI_KB == 32);

	////////////////////////////////////////////////////////////////////////////////
	// Controller state
	////////////////////////////////////////////////////////////////////////////////

	// First cycle after reset release loads the field
	always_comb begin
		next_state = state;
		case (state)
			PFBS_ST_INIT: begin
				next_state = PFBS_ST_RUN;
			end
			PFBS_ST_RUN: begin
				next_state = PFBS_ST_RUN;
			end
			default: begin
				next_state = PFBS_ST_INIT;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= PFBS_ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start-up configuration bits
	////////////////////////////////////////////////////////////////////////////////

	// Only host-mode or programming commands may alter them
	assign cfg_ok = cfg_wr_i && ((cfg_src_i == PFBS_SRC_HOST) || (cfg_src_i == PFBS_SRC_IAP)); // R9

	// Nonvolatile bits, modelled as flops with the erased value at power-up
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			startup_cfg_bit0 <= 1'(`PFBS_SC_ERASED >> 0);
			startup_cfg_bit1 <= 1'(`PFBS_SC_ERASED >> 1);
		end else if (cfg_ok) begin
			startup_cfg_bit0 <= cfg_wdata_i[0]; // R9
			startup_cfg_bit1 <= cfg_wdata_i[1]; // R9
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Block-switch field
	////////////////////////////////////////////////////////////////////////////////

	// A reload comes from reset release or a reset event
	assign reload      = (state == PFBS_ST_INIT) || sys_rst_req_i; // R8
	assign reload_kind = (state == PFBS_ST_INIT) ? PFBS_RST_POR : sys_rst_kind_i;
	assign field_wr    = reg_wr_i && (reg_addr_i == `PFBS_OFS_FIELD) && (state == PFBS_ST_RUN);

	// Next field: reset loading first, then software write of bit 0
	always_comb begin
		next_field = block_switch_field;
		if (reload) begin
			case (reload_kind)
				PFBS_RST_POR: begin
					next_field = {~startup_cfg_bit1, ~startup_cfg_bit0}; // R12
				end
				PFBS_RST_WDT: begin
					next_field[0] = ~startup_cfg_bit0; // R12
					if (!startup_cfg_bit1) begin
						next_field[1] = 1'b1; // R12
					end
				end
				PFBS_RST_SOFT: begin
					next_field = {1'b1, ~startup_cfg_bit0}; // R12
				end
				default: begin
					next_field = {~startup_cfg_bit1, ~startup_cfg_bit0};
				end
			endcase
		end else if (field_wr) begin
			next_field[0] = reg_wdata_i[0]; // R10
		end
	end

	// Field register; start-up bits untouched by software writes
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			block_switch_field <= `PFBS_FIELD_RST;
		end else begin
			block_switch_field <= next_field; // R8 R10
		end
	end

	// Last reset kind, for software
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_kind <= PFBS_RST_POR;
		end else if (reload) begin
			last_kind <= reload_kind;
		end
	end

	// Delayed field copy, so the change pulse lags the field by one cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			field_d <= `PFBS_FIELD_RST;
		end else begin
			field_d <= block_switch_field;
		end
	end

	// Mapping-change pulse, one cycle after the field moves
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			map_changed_o <= 1'b0;
		end else begin
			map_changed_o <= (block_switch_field != field_d); // R10
		end
	end

	// Mirror of mapping state
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			block_switch_field_o <= `PFBS_FIELD_RST;
			startup_cfg_bit0_o   <= 1'(`PFBS_SC_ERASED >> 0);
			startup_cfg_bit1_o   <= 1'(`PFBS_SC_ERASED >> 1);
		end else begin
			block_switch_field_o <= next_field;
			startup_cfg_bit0_o   <= cfg_ok ? cfg_wdata_i[0] : startup_cfg_bit0;
			startup_cfg_bit1_o   <= cfg_ok ? cfg_wdata_i[1] : startup_cfg_bit1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decoders
	////////////////////////////////////////////////////////////////////////////////

	// Fetch path follows the current field
	pfbs_decode #(
		.PRI_KB (PRI_KB)
	) u_fetch_dec (
		.prog_i  (1'b0),
		.field_i (block_switch_field), // R13
		.addr_i  (fetch_i.addr),
		.map_o   (fetch_map)
	);

	// Programming path sees both blocks whatever the field
	pfbs_decode #(
		.PRI_KB (PRI_KB)
	) u_prog_dec (
		.prog_i  (1'b1),
		.field_i (block_switch_field),
		.addr_i  (prog_i.addr),
		.map_o   (prog_map)
	);

	// Registered fetch answer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fetch_valid_o <= 1'b0;
			fetch_map_o   <= '0;
		end else begin
			fetch_valid_o <= fetch_i.req && (state == PFBS_ST_RUN);
			if (fetch_i.req) begin
				fetch_map_o <= fetch_map; // R13
			end
		end
	end

	// Registered programming answer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_valid_o <= 1'b0;
			prog_map_o   <= '0;
		end else begin
			prog_valid_o <= prog_i.req && (state == PFBS_ST_RUN);
			if (prog_i.req) begin
				prog_map_o <= prog_map; // R4 R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port
	////////////////////////////////////////////////////////////////////////////////

	// Status word: reset kind, size variant, running
	always_comb begin
		status_word = 8'h00;
		status_word[`PFBS_ST_KIND_LSB+1:`PFBS_ST_KIND_LSB] = last_kind;
		status_word[`PFBS_ST_BIG_BIT] = BIG_VARIANT; // R1
		status_word[`PFBS_ST_RUN_BIT] = (state == PFBS_ST_RUN);
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr_i == `PFBS_OFS_FIELD) begin
			next_rdata = {6'h00, block_switch_field};
		end else if (reg_addr_i == `PFBS_OFS_CFG) begin
			next_rdata = {6'h00, startup_cfg_bit1, startup_cfg_bit0};
		end else if (reg_addr_i == `PFBS_OFS_STATUS) begin
			next_rdata = status_word;
		end
	end

	// Read data stands for one cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= `PFBS_RDATA_RST;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= `PFBS_RDATA_RST;
		end
	end

endmodule // pfbs_top

// ===== pfbs_props.sv
`timescale 1ns/1ps
module pfbs_props #(
	parameter int PRI_KB = 32
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_req_i,
	input pfbs_pkg::pfbs_rst_kind_t sys_rst_kind_i,
	input wire logic cfg_wr_i,
	input pfbs_pkg::pfbs_cfg_src_t cfg_src_i,
	input pfbs_pkg::pfbs_req_t fetch_i,
	input wire logic fetch_valid_o,
	input pfbs_pkg::pfbs_map_t fetch_map_o,
	input pfbs_pkg::pfbs_req_t prog_i,
	input wire logic prog_valid_o,
	input pfbs_pkg::pfbs_map_t prog_map_o,
	input wire logic [1:0] block_switch_field_o,
	input wire logic startup_cfg_bit0_o,
	input wire logic startup_cfg_bit1_o,
	input wire logic map_changed_o
);
	import pfbs_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	// Reset events by kind
	sequence s_por; sys_rst_req_i && sys_rst_kind_i == PFBS_RST_POR; endsequence
	sequence s_soft; sys_rst_req_i && sys_rst_kind_i == PFBS_RST_SOFT; endsequence
	// Fetch answers decoded with the field seen at the request
	sequence s_low_ovl;
		fetch_valid_o && $past(block_switch_field_o) == 2'h0 && $past(fetch_i.addr) <= 16'h1FFF;
	endsequence
	////////////////////////////////////////
	property p_fv; fetch_valid_o |-> $past(fetch_i.req); endproperty
	a_fv: assert property (p_fv) else $error("fetch answer without request");
	property p_ovl;
		s_low_ovl |-> fetch_map_o.blk == PFBS_BLK_SEC
			&& fetch_map_o.sector == {2'h0, $past(fetch_i.addr[12:7])};
	endproperty
	a_ovl: assert property (p_ovl) else $error("low fetch not from secondary");
	property p_hide; fetch_valid_o && $past(block_switch_field_o[1]) |-> fetch_map_o.blk != PFBS_BLK_SEC; endproperty
	a_hide: assert property (p_hide) else $error("hidden block fetched");
	property p_prog; prog_valid_o && $past(prog_i.addr) >= 16'hE000 |-> prog_map_o.blk == PFBS_BLK_SEC; endproperty
	a_prog: assert property (p_prog) else $error("programming miss on secondary");
	property p_por; s_por |=> block_switch_field_o == ~$past({startup_cfg_bit1_o, startup_cfg_bit0_o}); endproperty
	a_por: assert property (p_por) else $error("power-on field wrong");
	property p_soft; s_soft |=> block_switch_field_o == {1'b1, ~$past(startup_cfg_bit0_o)}; endproperty
	a_soft: assert property (p_soft) else $error("software reset field wrong");
	property p_none;
		cfg_wr_i && cfg_src_i == PFBS_SRC_NONE |=> $stable({startup_cfg_bit1_o, startup_cfg_bit0_o});
	endproperty
	a_none: assert property (p_none) else $error("start-up bits changed");
	property p_chg; !$stable(block_switch_field_o) |=> map_changed_o; endproperty
	a_chg: assert property (p_chg) else $error("map change not flagged");
endmodule // pfbs_props

bind pfbs_top pfbs_props #(.PRI_KB(PRI_KB)) u_props (.*);

// ===== pfbs_cpu_model.sv
`timescale 1ns/1ps
module pfbs_cpu_model (
	input wire logic ref_clk_i,
	output pfbs_pkg::pfbs_req_t fetch_o,
	output pfbs_pkg::pfbs_req_t prog_o
);
	import pfbs_pkg::*;
	initial begin
		fetch_o = '0;
		prog_o = '0;
	end
	// One-cycle request; address inverted once released
	task automatic access(input logic [15:0] a, input bit p);
		@(posedge ref_clk_i);
		if (p) prog_o <= '{1'b1, a};
		else fetch_o <= '{1'b1, a};
		@(posedge ref_clk_i);
		if (p) prog_o <= '{1'b0, ~a};
		else fetch_o <= '{1'b0, ~a};
	endtask
endmodule // pfbs_cpu_model

// ===== program_flash_block_switch_tb_top.sv
`timescale 1ns/1ps
module program_flash_block_switch_tb_top;
	import pfbs_pkg::*;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic sys_rst_req_i = 1'b0, cfg_wr_i = 1'b0;
	logic fetch_valid_o, prog_valid_o, startup_cfg_bit0_o, startup_cfg_bit1_o, map_changed_o;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic [1:0] cfg_wdata_i = 2'h0, block_switch_field_o, fld = 2'h0;
	pfbs_rst_kind_t sys_rst_kind_i = PFBS_RST_POR;
	pfbs_cfg_src_t cfg_src_i = PFBS_SRC_NONE;
	pfbs_req_t fetch_i, prog_i;
	pfbs_map_t fetch_map_o, prog_map_o;
	int num_errors = 0, comparisons = 0;
	logic [15:0] addrs [9] = '{16'h0000, 16'h0080, 16'h1FFF, 16'h2000,
		16'h7FFF, 16'h8000, 16'hE000, 16'hE5AB, 16'hFFFF};
	pfbs_top u_dut (.*);
	pfbs_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .fetch_o(fetch_i), .prog_o(prog_i));
	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Expected decode, 32 KByte primary
	function automatic pfbs_map_t em(input logic [1:0] f, input logic [15:0] a, input bit p);
		pfbs_map_t m;
		m = '{PFBS_BLK_NONE, 8'h00, a[6:0]};
		if ((a >= 16'hE000 && (p || f == 2'h1)) || (!p && f == 2'h0 && a <= 16'h1FFF))
			m = '{PFBS_BLK_SEC, {2'h0, a[12:7]}, a[6:0]};
		else if (a < 16'h8000)
			m = '{PFBS_BLK_PRI, a[14:7], a[6:0]};
		return m;
	endfunction
	task automatic pulse_rst(input pfbs_rst_kind_t k);
		@(posedge ref_clk_i);
		sys_rst_req_i <= 1'b1;
		sys_rst_kind_i <= k;
		@(posedge ref_clk_i);
		sys_rst_req_i <= 1'b0;
		#1;
	endtask
	task automatic set_cfg(input pfbs_cfg_src_t s, input logic [1:0] d);
		@(posedge ref_clk_i);
		cfg_wr_i <= 1'b1;
		cfg_src_i <= s;
		cfg_wdata_i <= d;
		@(posedge ref_clk_i);
		cfg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask
	task automatic acc_chk(input logic [15:0] a, input bit p);
		u_cpu.access(a, p);
		#1;
		chk(p ? prog_valid_o : fetch_valid_o, 1'b1);
		chk(p ? prog_map_o : fetch_map_o, em(fld, a, p));
	endtask
	////////////////////////////////////////
	// Every start-up setting against every reset kind
	task automatic t_reset_table();
		for (int c = 0; c < 4; c++) begin
			set_cfg(c[0] ? PFBS_SRC_HOST : PFBS_SRC_IAP, c[1:0]);
			set_cfg(PFBS_SRC_NONE, ~c[1:0]);
			chk({startup_cfg_bit1_o, startup_cfg_bit0_o}, c);
			for (int k = 0; k < 3; k++) begin
				pulse_rst(pfbs_rst_kind_t'(k));
				if (k == 0) fld = ~c[1:0];
				else if (k == 2) fld = {1'b1, ~c[0]};
				else fld = {fld[1] | ~c[1], ~c[0]};
				chk(block_switch_field_o, fld);
			end
		end
	endtask
	// Fetch and programming decode in all four mappings
	task automatic t_fetch_map();
		for (int f = 0; f < 4; f++) begin
			set_cfg(PFBS_SRC_HOST, ~f[1:0]);
			pulse_rst(PFBS_RST_POR);
			fld = f[1:0];
			foreach (addrs[i]) begin
				acc_chk(addrs[i], 1'b0);
				acc_chk(addrs[i], 1'b1);
			end
		end
	endtask
	// Software flips bit 0; bit 1 and the start-up bits hold
	task automatic t_sw_switch();
		set_cfg(PFBS_SRC_HOST, 2'h3);
		pulse_rst(PFBS_RST_POR);
		reg_wr(4'h0, 8'h01); // Issued with no fetch in the low range
		fld = 2'h1;
		@(posedge ref_clk_i);
		#1;
		chk(map_changed_o, 1'b1);
		rd_chk(4'h0, 8'h01);
		chk(startup_cfg_bit0_o, 1'b1);
		acc_chk(16'h0080, 1'b0);
		reg_wr(4'h0, 8'h02);
		fld = 2'h0;
		rd_chk(4'h0, 8'h00);
		acc_chk(16'h0080, 1'b0);
		reg_wr(4'h1, 8'h00);
		rd_chk(4'h1, 8'h03);
		rd_chk(4'h5, 8'h00);
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk({block_switch_field_o, startup_cfg_bit1_o, startup_cfg_bit0_o}, 4'h3);
		t_reset_table();
		t_fetch_map();
		t_sw_switch();
		print_verdict();
	end
	// Watchdog against a hang
	initial begin
		#200000;
		num_errors++;
		print_verdict();
	end
endmodule // program_flash_block_switch_tb_top
